// ---- rtl/quad_phase_fetch_execute_timing.sv ----
`timescale 1ns/100ps
`include "qp_timing_params.svh"
// How it works
// - input clock divided by four into four rotating one-hot phases
// - program counter advances in phase one of every cycle
// - fetched word captured in phase four, usable next phase one
// - fetched word executes across the whole following cycle
// - fetch of next word overlaps execution, one instruction per cycle
// - a jump flushes the prefetched word, costing two cycles
// - operand read strobe in phase two, result write in phase four
// - in rc mode divided clock out runs at a quarter input rate
// - low master clear resets the device
// - one whole 14-bit word fetched per instruction cycle
module quad_phase_fetch_execute_timing #(
    parameter int INSN_W = `QP_INSN_W,
    parameter int PC_W = `QP_PC_W
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic master_clear_n_i,
    input wire logic rc_mode_i,
    input wire logic [INSN_W-1:0] prog_word_i,
    input wire logic jump_i,
    input wire logic [PC_W-1:0] jump_target_i,
    output logic phase_one_o,
    output logic phase_two_o,
    output logic phase_three_o,
    output logic phase_four_o,
    output logic [PC_W-1:0] prog_addr_o,
    output logic [INSN_W-1:0] instruction_hold_reg_o,
    output logic exec_valid_o,
    output logic data_read_o,
    output logic data_write_o,
    output logic divided_clock_out_o,
    output logic divided_clock_oe_o
);
    // master clear from the pin: three-stage synchroniser
    logic master_clear_n_s1_r, master_clear_n_s2_r, master_clear_n_s3_r, master_clear_n_low_r;
    logic master_clear_n_low_nxt;
    logic hold;
    qp_timing_pkg::phase_e phase;
    qp_timing_pkg::phase_e phase_next;
    logic [3:0] onehot_nxt;
    logic [3:0] onehot_r;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [INSN_W-1:0] ir_r, ir_nxt;
    logic [INSN_W-1:0] fetch_r, fetch_nxt;
    logic fetch_ok_r, fetch_ok_nxt;
    logic exec_ok_r, exec_ok_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt;
    logic div_r, div_nxt, oe_r, oe_nxt;

    // filtered level changes only when stages two and three agree
    always_comb
    begin
        master_clear_n_low_nxt = master_clear_n_low_r;
        if (master_clear_n_s2_r == master_clear_n_s3_r)
            master_clear_n_low_nxt = ~master_clear_n_s3_r;
    end

    always_ff @(posedge core_clk_i)
    begin
        master_clear_n_s1_r <= master_clear_n_i;
        master_clear_n_s2_r <= master_clear_n_s1_r;
        master_clear_n_s3_r <= master_clear_n_s2_r;
        if (rst_i)
            master_clear_n_low_r <= 1'b1;
        else
            master_clear_n_low_r <= master_clear_n_low_nxt;
    end

    assign hold = rst_i | master_clear_n_low_r;

    phase_gen u_phase (
        .core_clk_i(core_clk_i),
        .rst_i(hold),
        .phase_o(phase)
    );

    // look one phase ahead so every output is a plain flip-flop
    always_comb
    begin
        unique case (phase)
            qp_timing_pkg::PH_ONE: phase_next = qp_timing_pkg::PH_TWO;
            qp_timing_pkg::PH_TWO: phase_next = qp_timing_pkg::PH_THREE;
            qp_timing_pkg::PH_THREE: phase_next = qp_timing_pkg::PH_FOUR;
            qp_timing_pkg::PH_FOUR: phase_next = qp_timing_pkg::PH_ONE;
        endcase
        onehot_nxt = 4'h0;
        onehot_nxt[phase_next] = 1'b1;
    end

    // pipeline state, advanced once per phase
    always_comb
    begin
        pc_nxt = pc_r;
        ir_nxt = ir_r;
        fetch_nxt = fetch_r;
        fetch_ok_nxt = fetch_ok_r;
        exec_ok_nxt = exec_ok_r;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        unique case (phase)
            qp_timing_pkg::PH_ONE:
            begin
                // hand fetched word to execute stage
                ir_nxt = fetch_r;
                exec_ok_nxt = fetch_ok_r;
                pc_nxt = PC_W'(pc_r + 1'b1);
                rd_nxt = fetch_ok_r; // next phase is phase two
            end
            qp_timing_pkg::PH_TWO:
            begin
                rd_nxt = 1'b0;
            end
            qp_timing_pkg::PH_THREE:
            begin
                wr_nxt = exec_ok_r;
            end
            qp_timing_pkg::PH_FOUR:
            begin
                // whole word captured at once from the program bus
                fetch_nxt = prog_word_i;
                fetch_ok_nxt = 1'b1;
                if (exec_ok_r && jump_i)
                begin
                    // prefetched word is wrong: flush it
                    fetch_ok_nxt = 1'b0;
                    pc_nxt = jump_target_i;
                end
            end
        endcase
    end

    // rc mode: high for phases one and two, low for three and four
    always_comb
    begin
        oe_nxt = rc_mode_i;
        div_nxt = rc_mode_i &&
            (phase_next == qp_timing_pkg::PH_ONE ||
             phase_next == qp_timing_pkg::PH_TWO);
    end

    // a jump target loads at the end of phase four; the address bus is
    // the pc register itself, stepped at the end of every phase one
    always_ff @(posedge core_clk_i)
    begin
        if (hold)
        begin
            onehot_r <= 4'h1;
            pc_r <= `QP_PC_RESET;
            ir_r <= `QP_INSN_RESET;
            fetch_r <= `QP_INSN_RESET;
            fetch_ok_r <= 1'b0;
            exec_ok_r <= 1'b0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            div_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else
        begin
            onehot_r <= onehot_nxt;
            pc_r <= pc_nxt;
            ir_r <= ir_nxt;
            fetch_r <= fetch_nxt;
            fetch_ok_r <= fetch_ok_nxt;
            exec_ok_r <= exec_ok_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            div_r <= div_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign phase_one_o = onehot_r[0];
    assign phase_two_o = onehot_r[1];
    assign phase_three_o = onehot_r[2];
    assign phase_four_o = onehot_r[3];
    assign prog_addr_o = pc_r;
    assign instruction_hold_reg_o = ir_r;
    assign exec_valid_o = exec_ok_r;
    assign data_read_o = rd_r;
    assign data_write_o = wr_r;
    assign divided_clock_out_o = div_r;
    assign divided_clock_oe_o = oe_r;

    AST_ONEHOT: assert property (@(posedge core_clk_i)
        disable iff (hold) $onehot(onehot_r))
        else $error("phases overlap");
    AST_ROTATE: assert property (@(posedge core_clk_i)
        disable iff (hold)
        phase_one_o |=> phase_two_o ##1 phase_three_o ##1 phase_four_o)
        else $error("phase rotation broken");
    AST_RD_Q2: assert property (@(posedge core_clk_i)
        disable iff (hold) data_read_o |-> phase_two_o && exec_valid_o)
        else $error("read outside phase two");
    AST_WR_Q4: assert property (@(posedge core_clk_i)
        disable iff (hold) data_write_o |-> phase_four_o && exec_valid_o)
        else $error("write outside phase four");
    AST_EXEC_RW: assert property (@(posedge core_clk_i)
        disable iff (hold)
        phase_two_o && exec_valid_o |-> data_read_o ##2 data_write_o)
        else $error("execute cycle lacks strobes");
    AST_FLUSH: assert property (@(posedge core_clk_i)
        disable iff (hold) phase_four_o && exec_valid_o && jump_i |=>
        phase_one_o ##1 !exec_valid_o) else $error("jump did not flush");
    AST_PC_STEP: assert property (@(posedge core_clk_i)
        disable iff (hold) phase_one_o && !$past(hold) |=>
        prog_addr_o == PC_W'($past(prog_addr_o) + 1'b1))
        else $error("pc did not advance");
    AST_DIVCLK: assert property (@(posedge core_clk_i)
        disable iff (hold) phase_one_o && oe_r && $past(rc_mode_i) &&
        rc_mode_i |-> divided_clock_out_o)
        else $error("divided clock wrong");
    AST_IR_LOAD: assert property (@(posedge core_clk_i)
        disable iff (hold) phase_four_o ##1 phase_one_o |=>
        instruction_hold_reg_o == $past(prog_word_i, 2))
        else $error("word not captured");
    // divided clock may only be high in the first half of a cycle
    AST_DIV_LOW: assert property (@(posedge core_clk_i)
        disable iff (hold) divided_clock_out_o |->
        (phase_one_o || phase_two_o) && divided_clock_oe_o)
        else $error("divided clock outside first half");
    AST_IR_STANDS: assert property (@(posedge core_clk_i)
        disable iff (hold) !phase_two_o |->
        $stable(instruction_hold_reg_o) && $stable(exec_valid_o))
        else $error("held word changed mid cycle");
    AST_PC_HOLD: assert property (@(posedge core_clk_i)
        disable iff (hold) phase_two_o || phase_three_o |=>
        $stable(prog_addr_o)) else $error("pc moved outside phase one");
endmodule // quad_phase_fetch_execute_timing

// ---- rtl/qp_timing_params.svh ----
`ifndef QP_TIMING_PARAMS_SVH
`define QP_TIMING_PARAMS_SVH
// input clock cycles per instruction cycle
`define QP_PHASES 4
`define QP_PHASE_W 2
// instruction word width
`define QP_INSN_W 14
// program counter width
`define QP_PC_W 13
// program counter value after reset
`define QP_PC_RESET 13'h0000
// empty instruction holder value (no operation)
`define QP_INSN_RESET 14'h0000
// divided clock high for the first half of each instruction cycle
`define QP_DIV_HIGH_PHASES 2
`endif

// ---- rtl/qp_timing_pkg.sv ----
package qp_timing_pkg;
    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} phase_e;
endpackage

// ---- rtl/phase_gen.sv ----
`timescale 1ns/100ps
`include "qp_timing_params.svh"
// four-phase rotation, one input clock per phase
module phase_gen (
    input wire logic core_clk_i,
    input wire logic rst_i,
    output qp_timing_pkg::phase_e phase_o
);
    qp_timing_pkg::phase_e phase_r;
    qp_timing_pkg::phase_e phase_nxt;

    // fixed rotation; reset parks on the first phase
    always_comb
    begin
        unique case (phase_r)
            qp_timing_pkg::PH_ONE: phase_nxt = qp_timing_pkg::PH_TWO;
            qp_timing_pkg::PH_TWO: phase_nxt = qp_timing_pkg::PH_THREE;
            qp_timing_pkg::PH_THREE: phase_nxt = qp_timing_pkg::PH_FOUR;
            qp_timing_pkg::PH_FOUR: phase_nxt = qp_timing_pkg::PH_ONE;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            phase_r <= qp_timing_pkg::PH_ONE;
        else
            phase_r <= phase_nxt;
    end

    assign phase_o = phase_r;
endmodule // phase_gen

// ---- sim/prog_source.sv ----
`timescale 1ns/100ps
`include "qp_timing_params.svh"
// far side: program memory and the reset pin driver
module prog_source (
    input wire logic clear_req_i,
    input wire logic [`QP_PC_W-1:0] addr_i,
    output logic [`QP_INSN_W-1:0] word_o,
    output logic master_clear_n_o
);
    // word tied to its address so the bench can predict every fetch
    assign word_o = {1'b1, addr_i};
    // reset is asserted by pulling the pin low
    assign master_clear_n_o = !clear_req_i;
endmodule // prog_source

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`include "qp_timing_params.svh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clear_req = 1'b0;
    logic rc_mode = 1'b0;
    logic jump = 1'b0;
    logic [12:0] target = 13'h0000;
    logic p1, p2, p3, p4, rd, wr, valid, dclk, doe, master_clear_n_n;
    logic [3:0] phs;
    logic [12:0] addr, pc_seen;
    logic [13:0] word, ir;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    assign phs = {p4, p3, p2, p1};
    // 40 MHz core clock
    always #12.5 clk = !clk;
    quad_phase_fetch_execute_timing dut_u (
        .core_clk_i(clk), .rst_i(rst), .master_clear_n_i(master_clear_n_n),
        .rc_mode_i(rc_mode), .prog_word_i(word), .jump_i(jump),
        .jump_target_i(target), .phase_one_o(p1), .phase_two_o(p2),
        .phase_three_o(p3), .phase_four_o(p4), .prog_addr_o(addr),
        .instruction_hold_reg_o(ir), .exec_valid_o(valid),
        .data_read_o(rd), .data_write_o(wr),
        .divided_clock_out_o(dclk), .divided_clock_oe_o(doe)
    );
    prog_source mem_u (
        .clear_req_i(clear_req), .addr_i(addr), .word_o(word),
        .master_clear_n_o(master_clear_n_n)
    );
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // sample just after the edge so registered outputs have settled
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    // bounded wait; the reset pin filter delays the first phase two
    task automatic wait_ph(input int n);
        int k;
        k = 0;
        step();
        while (phs[n-1] !== 1'b1 && k < 16)
        begin
            step();
            k++;
        end
        if (phs[n-1] !== 1'b1)
            chk("phase reached", 16'h0001, 16'h0000);
    endtask
    task automatic t_reset;
        repeat (11) step();
        chk("phases in reset", 16'h0001, phs);
        chk("valid in reset", 16'h0000, valid);
        chk("oe in reset", 16'h0000, doe);
        @(posedge clk);
        rst <= 1'b0;
        wait_ph(2);
        chk("valid first cycle", 16'h0000, valid);
        chk("pc first cycle", 16'h0001, addr);
    endtask
    // back-to-back instructions, one per rotation
    task automatic t_flow;
        wait_ph(4);
        repeat (3)
        begin
            pc_seen = addr;
            chk("phase four", 16'h0008, phs);
            step();
            chk("phase one", 16'h0001, phs);
            step();
            chk("pc advance", pc_seen + 13'h0001, addr);
            chk("held word", {1'b1, pc_seen}, ir);
            chk("valid", 16'h0001, valid);
            chk("read strobe", 16'h0001, rd);
            step();
            chk("read ends", 16'h0000, rd);
            step();
            chk("write strobe", 16'h0001, wr);
            chk("word stands", {1'b1, pc_seen}, ir);
        end
    endtask
    task automatic t_jump;
        wait_ph(3);
        @(posedge clk);
        jump <= 1'b1;
        target <= 13'h0155;
        @(posedge clk);
        jump <= 1'b0;
        #1;
        chk("pc jump", 16'h0155, addr);
        step();
        chk("flushed valid", 16'h0000, valid);
        chk("flushed read", 16'h0000, rd);
        step();
        step();
        chk("flushed write", 16'h0000, wr);
        pc_seen = addr;
        step();
        step();
        chk("word after jump", {1'b1, pc_seen}, ir);
        chk("valid after jump", 16'h0001, valid);
    endtask
    // divided clock high in phases one and two only
    task automatic t_rc;
        @(posedge clk);
        rc_mode <= 1'b1;
        wait_ph(1);
        for (int i = 0; i < 4; i++)
        begin
            chk("divided clock", (i < 2), dclk);
            chk("divided oe", 16'h0001, doe);
            step();
        end
        @(posedge clk);
        rc_mode <= 1'b0;
        wait_ph(1);
        chk("divided off", 16'h0000, {dclk, doe});
    endtask
    task automatic t_master_clear_n;
        @(posedge clk);
        clear_req <= 1'b1;
        repeat (10) step();
        chk("phases in clear", 16'h0001, phs);
        chk("pc in clear", 16'h0000, addr);
        chk("valid in clear", 16'h0000, valid);
        @(posedge clk);
        clear_req <= 1'b0;
        wait_ph(2);
        chk("valid after clear", 16'h0000, valid);
        chk("pc after clear", 16'h0001, addr);
    endtask
    // whole run is about a hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            finish_test();
        end
    end
    initial
    begin
        t_reset();
        t_flow();
        t_jump();
        t_rc();
        t_master_clear_n();
        t_flow();
        finish_test();
    end
endmodule // tb
